// ==== rtl/exec_params.svh ====
/*
 * Constants of the arithmetic, compare, skip and branch execution block:
 * status flag bit positions, reset values and per-instruction cycle counts.
 * Assumes it is included by its bare name wherever a constant is needed.
 */
// How it works
// - add-one, subtract-one, self test, zeroing: one cycle, only Z N V change; all-ones load writes FF
// - integer products land in the low register pair, two cycles, only Z and C
// - fractional products are shifted left once, two cycles, only Z and C
// - relative and pointer jumps take two cycles, absolute jump three, flags kept
// - relative/pointer calls three cycles, absolute four; returns four, interrupt return sets I
// - equal-skip skips the next instruction when both registers match, no flags
// - compares subtract without storing, update Z N V C H, one cycle
// - register-bit skips test one register bit, skip on clear or set
// - io-bit skips test one io register bit, skip on clear or set
// - indexed flag branches jump relative when the chosen flag is set or clear
// - signed ge branches on N xor V clear, signed less on it set
// - same-or-higher branches on carry clear, lower on carry set
// - equal/unequal test Z, negative/positive test N, carry branches test C
// - half-carry branches test H and leave flags untouched
// - transfer-bit branches test T
// - overflow branches test V and modify no flags
// - interrupt-state branches test the global interrupt enable
`ifndef EXEC_PARAMS_SVH
`define EXEC_PARAMS_SVH

`define FLAG_C 3'h0
`define FLAG_Z 3'h1
`define FLAG_N 3'h2
`define FLAG_V 3'h3
`define FLAG_S 3'h4
`define FLAG_H 3'h5
`define FLAG_T 3'h6
`define FLAG_I 3'h7

`define FLAGS_RESET 8'h00
`define PC_RESET 16'h0000
`define ALL_ONES 8'hFF

`define CYC_SINGLE 3'h1
`define CYC_PRODUCT 3'h2
`define CYC_REL_JUMP 3'h2
`define CYC_PTR_JUMP 3'h2
`define CYC_ABS_JUMP 3'h3
`define CYC_REL_CALL 3'h3
`define CYC_PTR_CALL 3'h3
`define CYC_ABS_CALL 3'h4
`define CYC_RESUME 3'h4
`define CYC_SKIP_NONE 3'h1
`define CYC_SKIP_ONE 3'h2
`define CYC_SKIP_TWO 3'h3
`define CYC_BR_NOT 3'h1
`define CYC_BR_TAKEN 3'h2

`endif

// ==== rtl/exec_pkg.sv ====
/*
 * Types shared by the execution block: operation codes, the status flags,
 * the request word and the write-back and stack words.
 * Assumes the instruction decoder outside fills the request word.
 */
`default_nettype none

package exec_pkg;

	typedef enum logic [5:0] {
		op_increment, op_decrement, op_self_and_test, op_zero_register,
		op_all_ones_load, op_product_unsigned, op_product_signed,
		op_product_mixed, op_fractional_product_unsigned,
		op_fractional_product_signed, op_fractional_product_mixed,
		op_relative_jump, op_pointer_jump, op_absolute_jump,
		op_relative_sub_jump, op_pointer_sub_jump, op_absolute_sub_jump,
		op_pop_resume, op_interrupt_resume, op_equal_skip,
		op_compare_regs, op_compare_with_borrow, op_compare_immediate,
		op_reg_bit_clear_skip, op_reg_bit_set_skip,
		op_io_bit_clear_skip, op_io_bit_set_skip,
		op_branch_flag_index_set, op_branch_flag_index_clear,
		op_branch_on_equal, op_branch_on_unequal,
		op_branch_carry_set, op_branch_carry_clear,
		op_branch_same_or_higher, op_branch_lower,
		op_branch_negative, op_branch_positive,
		op_branch_signed_ge, op_branch_signed_less,
		op_branch_halfcarry_set, op_branch_halfcarry_clear,
		op_branch_tflag_set, op_branch_tflag_clear,
		op_branch_overflow_set, op_branch_overflow_clear,
		op_branch_irq_on, op_branch_irq_off
	} exec_op_t;

	// bit 0 is carry, bit 7 the global interrupt enable
	typedef struct packed {
		logic i;
		logic t;
		logic h;
		logic s;
		logic v;
		logic n;
		logic z;
		logic c;
	} status_flags_t;

	typedef struct packed {
		exec_op_t op;
		logic [4:0] dest;
		logic [7:0] rd_val;
		logic [7:0] rr_val;
		logic [7:0] imm;
		logic [2:0] bit_sel;
		logic [7:0] io_val;
		logic [11:0] offset;
		logic [15:0] target;
		logic [15:0] zptr;
		logic [15:0] stack_word;
		logic next_two_word;
	} exec_req_t;

	typedef struct packed {
		logic reg_valid;
		logic [4:0] reg_idx;
		logic [7:0] reg_data;
		logic pair_valid;
		logic [15:0] pair_data;
	} wb_t;

	typedef struct packed {
		logic valid;
		logic [15:0] addr;
	} stack_op_t;

endpackage

`default_nettype wire

// ==== rtl/exec_alu.sv ====
/*
 * Result and flag arithmetic for the single-register, compare and product
 * operations. Purely combinational; the caller registers what it keeps.
 */
`timescale 1ns/1ps
`default_nettype none
`include "exec_params.svh"

module exec_alu (
	// operation and operands
	input wire exec_pkg::exec_op_t op,
	input wire logic [7:0] a,
	input wire logic [7:0] b,
	input wire logic [7:0] imm,
	input wire exec_pkg::status_flags_t flags_in,
	// results
	output logic [7:0] result,
	output logic result_wr,
	output logic [15:0] pair,
	output logic pair_wr,
	output exec_pkg::status_flags_t flags_out
);
	logic [7:0] sb;
	logic [8:0] diff;
	logic [15:0] xa;
	logic [15:0] xb;
	logic [31:0] full;
	logic [15:0] prod;

	always_comb begin
		sb = (op == exec_pkg::op_compare_immediate) ? imm : b;
		diff = {1'b0, a} - {1'b0, sb} -
			{8'h00, (op == exec_pkg::op_compare_with_borrow) & flags_in.c};
		case (op)
		exec_pkg::op_product_signed,
		exec_pkg::op_fractional_product_signed: begin
			xa = {{8{a[7]}}, a};
			xb = {{8{b[7]}}, b};
		end
		exec_pkg::op_product_mixed,
		exec_pkg::op_fractional_product_mixed: begin
			xa = {{8{a[7]}}, a};
			xb = {8'h00, b};
		end
		default: begin
			xa = {8'h00, a};
			xb = {8'h00, b};
		end
		endcase
		// 16-bit truncation of the widened product is exact for 8x8
		full = xa * xb;
		prod = full[15:0];
		result = a;
		result_wr = 1'b0;
		pair = prod;
		pair_wr = 1'b0;
		flags_out = flags_in;
		case (op)
		exec_pkg::op_increment: begin
			result = a + 8'h01;
			result_wr = 1'b1;
			flags_out.v = (a == 8'h7F);
		end
		exec_pkg::op_decrement: begin
			result = a - 8'h01;
			result_wr = 1'b1;
			flags_out.v = (a == 8'h80);
		end
		exec_pkg::op_self_and_test: begin
			result = a & a;
			result_wr = 1'b1;
			flags_out.v = 1'b0;
		end
		exec_pkg::op_zero_register: begin
			result = a ^ a;
			result_wr = 1'b1;
			flags_out.v = 1'b0;
		end
		exec_pkg::op_all_ones_load: begin
			result = `ALL_ONES;
			result_wr = 1'b1;
		end
		exec_pkg::op_product_unsigned, exec_pkg::op_product_signed,
		exec_pkg::op_product_mixed: begin
			pair_wr = 1'b1;
			flags_out.c = prod[15];
			flags_out.z = (prod == 16'h0000);
		end
		exec_pkg::op_fractional_product_unsigned,
		exec_pkg::op_fractional_product_signed,
		exec_pkg::op_fractional_product_mixed: begin
			pair = {prod[14:0], 1'b0};
			pair_wr = 1'b1;
			flags_out.c = prod[15];
			flags_out.z = (pair == 16'h0000);
		end
		exec_pkg::op_compare_regs, exec_pkg::op_compare_with_borrow,
		exec_pkg::op_compare_immediate: begin
			result = diff[7:0];
			flags_out.c = diff[8];
			flags_out.h = (~a[3] & sb[3]) | (sb[3] & diff[3]) |
				(diff[3] & ~a[3]);
			flags_out.v = (a[7] & ~sb[7] & ~diff[7]) |
				(~a[7] & sb[7] & diff[7]);
		end
		default: begin
		end
		endcase
		// zero and negative follow the byte result of the one-byte group
		case (op)
		exec_pkg::op_increment, exec_pkg::op_decrement,
		exec_pkg::op_self_and_test, exec_pkg::op_zero_register,
		exec_pkg::op_compare_regs, exec_pkg::op_compare_immediate: begin
			flags_out.z = (result == 8'h00);
			flags_out.n = result[7];
		end
		exec_pkg::op_compare_with_borrow: begin
			// chained compare: zero only stays set across the bytes
			flags_out.z = (result == 8'h00) & flags_in.z;
			flags_out.n = result[7];
		end
		default: begin
		end
		endcase
	end

endmodule

`default_nettype wire

// ==== rtl/exec_cond.sv ====
/*
 * Decides whether a branch is taken or a skip happens, from the status
 * flags, the tested operand bit or the equality of both registers. Combinational.
 */
`timescale 1ns/1ps
`default_nettype none
`include "exec_params.svh"

module exec_cond (
	// operation and inputs to test
	input wire exec_pkg::exec_op_t op,
	input wire exec_pkg::status_flags_t flags,
	input wire logic [7:0] a,
	input wire logic [7:0] b,
	input wire logic [2:0] bit_sel,
	input wire logic [7:0] io_val,
	// decision
	output logic take
);
	logic [7:0] fv;

	always_comb begin
		fv = flags;
		case (op)
		exec_pkg::op_equal_skip: take = (a == b);
		exec_pkg::op_reg_bit_clear_skip: take = ~b[bit_sel];
		exec_pkg::op_reg_bit_set_skip: take = b[bit_sel];
		exec_pkg::op_io_bit_clear_skip: take = ~io_val[bit_sel];
		exec_pkg::op_io_bit_set_skip: take = io_val[bit_sel];
		exec_pkg::op_branch_flag_index_set: take = fv[bit_sel];
		exec_pkg::op_branch_flag_index_clear: take = ~fv[bit_sel];
		exec_pkg::op_branch_on_equal: take = flags.z;
		exec_pkg::op_branch_on_unequal: take = ~flags.z;
		exec_pkg::op_branch_carry_set: take = flags.c;
		exec_pkg::op_branch_carry_clear: take = ~flags.c;
		exec_pkg::op_branch_same_or_higher: take = ~flags.c;
		exec_pkg::op_branch_lower: take = flags.c;
		exec_pkg::op_branch_negative: take = flags.n;
		exec_pkg::op_branch_positive: take = ~flags.n;
		exec_pkg::op_branch_signed_ge: take = ~(flags.n ^ flags.v);
		exec_pkg::op_branch_signed_less: take = flags.n ^ flags.v;
		exec_pkg::op_branch_halfcarry_set: take = flags.h;
		exec_pkg::op_branch_halfcarry_clear: take = ~flags.h;
		exec_pkg::op_branch_tflag_set: take = flags.t;
		exec_pkg::op_branch_tflag_clear: take = ~flags.t;
		exec_pkg::op_branch_overflow_set: take = flags.v;
		exec_pkg::op_branch_overflow_clear: take = ~flags.v;
		exec_pkg::op_branch_irq_on: take = flags.i;
		exec_pkg::op_branch_irq_off: take = ~flags.i;
		default: take = 1'b0;
		endcase
	end

endmodule

`default_nettype wire

// ==== rtl/cpu_arith_branch_exec.sv ====
/*
 * Execution stage for increment/decrement/test, products, jumps, calls,
 * returns, compares, skips and flag branches. Holds the program counter
 * and the status flags, and reports register write-back and stack use.
 * Assumes a decoder outside presents one decoded request at a time with
 * its operands already read, and owns the register file and the stack.
 */
`timescale 1ns/1ps
`default_nettype none
`include "exec_params.svh"

module cpu_arith_branch_exec (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// decoded request
	input wire logic req_valid,
	input wire exec_pkg::exec_req_t req,
	output logic req_ready,
	// direct flag load from the rest of the core
	input wire logic flags_load_valid,
	input wire exec_pkg::status_flags_t flags_load_data,
	// architectural state
	output logic [15:0] pc,
	output exec_pkg::status_flags_t status_flags,
	// effects of the retired instruction
	output exec_pkg::wb_t wb,
	output exec_pkg::stack_op_t push,
	output logic pop,
	output logic retire,
	output logic [2:0] op_cycles
);

	////////////////////////////////////////////////////////////////////////
	// datapath helpers

	logic [7:0] alu_result;
	logic alu_result_wr;
	logic [15:0] alu_pair;
	logic alu_pair_wr;
	exec_pkg::status_flags_t alu_flags;
	logic take;

	exec_alu u_alu (
		.op(req.op),
		.a(req.rd_val),
		.b(req.rr_val),
		.imm(req.imm),
		.flags_in(status_flags),
		.result(alu_result),
		.result_wr(alu_result_wr),
		.pair(alu_pair),
		.pair_wr(alu_pair_wr),
		.flags_out(alu_flags)
	);

	exec_cond u_cond (
		.op(req.op),
		.flags(status_flags),
		.a(req.rd_val),
		.b(req.rr_val),
		.bit_sel(req.bit_sel),
		.io_val(req.io_val),
		.take(take)
	);

	////////////////////////////////////////////////////////////////////////
	// sequencing: an instruction is taken in one cycle and then holds the
	// request port for its remaining cycles

	typedef enum logic {run, stall} seq_state_t;

	seq_state_t state;
	seq_state_t next_state;
	logic [1:0] remain;
	logic [1:0] next_remain;
	logic [2:0] cycles;
	logic accept;

	assign req_ready = (state == run);
	assign accept = req_valid & req_ready;

	function automatic logic is_branch(input exec_pkg::exec_op_t o);
		is_branch = (o >= exec_pkg::op_branch_flag_index_set);
	endfunction

	// cycle count of the instruction being taken
	always_comb begin
		case (req.op)
		exec_pkg::op_product_unsigned, exec_pkg::op_product_signed,
		exec_pkg::op_product_mixed,
		exec_pkg::op_fractional_product_unsigned,
		exec_pkg::op_fractional_product_signed,
		exec_pkg::op_fractional_product_mixed:
			cycles = `CYC_PRODUCT;
		exec_pkg::op_relative_jump: cycles = `CYC_REL_JUMP;
		exec_pkg::op_pointer_jump: cycles = `CYC_PTR_JUMP;
		exec_pkg::op_absolute_jump: cycles = `CYC_ABS_JUMP;
		exec_pkg::op_relative_sub_jump: cycles = `CYC_REL_CALL;
		exec_pkg::op_pointer_sub_jump: cycles = `CYC_PTR_CALL;
		exec_pkg::op_absolute_sub_jump: cycles = `CYC_ABS_CALL;
		exec_pkg::op_pop_resume,
		exec_pkg::op_interrupt_resume: cycles = `CYC_RESUME;
		exec_pkg::op_equal_skip, exec_pkg::op_reg_bit_clear_skip,
		exec_pkg::op_reg_bit_set_skip, exec_pkg::op_io_bit_clear_skip,
		exec_pkg::op_io_bit_set_skip: begin
			if (!take) begin
				cycles = `CYC_SKIP_NONE;
			end else if (req.next_two_word) begin
				cycles = `CYC_SKIP_TWO;
			end else begin
				cycles = `CYC_SKIP_ONE;
			end
		end
		default: begin
			if (is_branch(req.op)) begin
				cycles = take ? `CYC_BR_TAKEN : `CYC_BR_NOT;
			end else begin
				cycles = `CYC_SINGLE;
			end
		end
		endcase
	end

	always_comb begin
		next_state = state;
		next_remain = remain;
		case (state)
		run: begin
			if (accept && cycles != `CYC_SINGLE) begin
				next_remain = 2'(cycles - 3'h2);
				next_state = stall;
			end
		end
		stall: begin
			if (remain == 2'h0) begin
				next_state = run;
			end else begin
				next_remain = remain - 2'h1;
			end
		end
		default: begin
			next_state = run;
			next_remain = 2'h0;
		end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state <= run;
			remain <= 2'h0;
		end else begin
			state <= next_state;
			remain <= next_remain;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// program counter and stack traffic

	logic [15:0] next_pc;
	logic [15:0] seq_pc;
	logic [15:0] rel_pc;
	logic [15:0] skip_pc;
	exec_pkg::stack_op_t next_push;
	logic next_pop;

	always_comb begin
		seq_pc = pc + 16'h0001;
		// relative target is pc + offset + 1, offset sign-extended
		rel_pc = pc + {{4{req.offset[11]}}, req.offset} + 16'h0001;
		skip_pc = pc + (req.next_two_word ? 16'h0003 : 16'h0002);
		next_pc = pc;
		next_push = '0;
		next_pop = 1'b0;
		if (accept) begin
			next_pc = seq_pc;
			case (req.op)
			exec_pkg::op_relative_jump: next_pc = rel_pc;
			exec_pkg::op_pointer_jump: next_pc = req.zptr;
			exec_pkg::op_absolute_jump: next_pc = req.target;
			exec_pkg::op_relative_sub_jump: begin
				next_pc = rel_pc;
				next_push = '{valid: 1'b1, addr: seq_pc};
			end
			exec_pkg::op_pointer_sub_jump: begin
				next_pc = req.zptr;
				next_push = '{valid: 1'b1, addr: seq_pc};
			end
			exec_pkg::op_absolute_sub_jump: begin
				// the call word carries its target, so return skips two
				next_pc = req.target;
				next_push = '{valid: 1'b1, addr: pc + 16'h0002};
			end
			exec_pkg::op_pop_resume, exec_pkg::op_interrupt_resume: begin
				next_pc = req.stack_word;
				next_pop = 1'b1;
			end
			exec_pkg::op_equal_skip, exec_pkg::op_reg_bit_clear_skip,
			exec_pkg::op_reg_bit_set_skip, exec_pkg::op_io_bit_clear_skip,
			exec_pkg::op_io_bit_set_skip: begin
				if (take) begin
					next_pc = skip_pc;
				end
			end
			default: begin
				if (is_branch(req.op) && take) begin
					next_pc = rel_pc;
				end
			end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			pc <= `PC_RESET;
			push <= '0;
			pop <= 1'b0;
		end else begin
			pc <= next_pc;
			push <= next_push;
			pop <= next_pop;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// status flags and register write-back

	exec_pkg::status_flags_t next_flags;
	exec_pkg::wb_t next_wb;
	logic [2:0] next_op_cycles;

	always_comb begin
		next_flags = status_flags;
		next_wb = '0;
		next_op_cycles = op_cycles;
		if (accept) begin
			// jumps, skips and branches fall through with flags kept
			next_flags = alu_flags;
			if (req.op == exec_pkg::op_interrupt_resume) begin
				next_flags.i = 1'b1;
			end
			next_wb.reg_valid = alu_result_wr;
			next_wb.reg_idx = req.dest;
			next_wb.reg_data = alu_result;
			next_wb.pair_valid = alu_pair_wr;
			next_wb.pair_data = alu_pair;
			next_op_cycles = cycles;
		end else if (flags_load_valid) begin
			// an executing instruction's flag update outranks this load
			next_flags = flags_load_data;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			status_flags <= `FLAGS_RESET;
			wb <= '0;
			retire <= 1'b0;
			op_cycles <= 3'h0;
		end else begin
			status_flags <= next_flags;
			wb <= next_wb;
			retire <= accept;
			op_cycles <= next_op_cycles;
		end
	end

endmodule

`default_nettype wire

// ==== bench/exec_checker.sv ====
/*
 * Checker for the execution block: cycle counts, program counter moves,
 * write-back and flag effects of accepted requests.
 * Assumes it sees only the block's ports; it is bound at the foot.
 */
`timescale 1ns/1ps
`default_nettype none

module exec_checker (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// request side
	input wire logic req_valid,
	input wire exec_pkg::exec_req_t req,
	input wire logic req_ready,
	input wire logic flags_load_valid,
	input wire exec_pkg::status_flags_t flags_load_data,
	// results
	input wire logic [15:0] pc,
	input wire exec_pkg::status_flags_t status_flags,
	input wire exec_pkg::wb_t wb,
	input wire exec_pkg::stack_op_t push,
	input wire logic pop,
	input wire logic retire,
	input wire logic [2:0] op_cycles
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	logic acc;
	logic [15:0] rel_step;
	exec_pkg::exec_op_t op;
	assign acc = req_valid && req_ready;
	assign op = req.op;
	assign rel_step = {{4{req.offset[11]}}, req.offset} + 16'h0001;

	////////////////////////////////////////////////////////////////////////
	single_cycle_a: assert property (
		acc && op inside {exec_pkg::op_increment, exec_pkg::op_decrement,
		exec_pkg::op_zero_register} |=> retire && op_cycles == 3'h1
		&& req_ready) else $error("one-cycle op not one cycle");
	all_ones_a: assert property (
		acc && op == exec_pkg::op_all_ones_load |=> wb.reg_valid
		&& wb.reg_data == 8'hFF && $stable(status_flags))
		else $error("all-ones load wrong");
	product_time_a: assert property (
		acc && op inside {[exec_pkg::op_product_unsigned:
		exec_pkg::op_fractional_product_mixed]} |=> wb.pair_valid
		&& !req_ready ##1 req_ready) else $error("product timing wrong");
	product_flags_a: assert property (
		acc && op inside {[exec_pkg::op_product_unsigned:
		exec_pkg::op_fractional_product_mixed]} |=>
		(status_flags & 8'hFC) == ($past(status_flags) & 8'hFC)
		&& status_flags.z == (wb.pair_data == 16'h0000))
		else $error("product flags wrong");
	abs_jump_a: assert property (
		acc && op == exec_pkg::op_absolute_jump |=>
		pc == $past(req.target) && !req_ready ##1 !req_ready ##1 req_ready)
		else $error("absolute jump wrong");
	call_push_a: assert property (
		acc && op == exec_pkg::op_absolute_sub_jump |=> push.valid
		&& push.addr == $past(pc) + 16'h0002 && op_cycles == 3'h4)
		else $error("absolute call wrong");
	resume_a: assert property (
		acc && op inside {exec_pkg::op_pop_resume,
		exec_pkg::op_interrupt_resume} |=> pop
		&& pc == $past(req.stack_word) && !req_ready ##1 !req_ready [*2]
		##1 req_ready)
		else $error("return wrong");
	compare_a: assert property (
		acc && op inside {[exec_pkg::op_compare_regs:
		exec_pkg::op_compare_immediate]} |=> !wb.reg_valid
		&& !wb.pair_valid && op_cycles == 3'h1) else $error("compare wrong");
	skip_pc_a: assert property (
		acc && op inside {exec_pkg::op_equal_skip,
		[exec_pkg::op_reg_bit_clear_skip:exec_pkg::op_io_bit_set_skip]}
		|=> pc == $past(pc) + {13'h0000, op_cycles}
		&& $stable(status_flags) && op_cycles != 3'h0
		&& op_cycles != ($past(req.next_two_word) ? 3'h2 : 3'h3))
		else $error("skip wrong");
	branch_a: assert property (
		acc && op inside {[exec_pkg::op_branch_flag_index_set:
		exec_pkg::op_branch_irq_off]} |=> $stable(status_flags)
		&& (op_cycles == 3'h1 && pc == $past(pc) + 16'h0001
		|| op_cycles == 3'h2 && pc == $past(pc) + $past(rel_step)))
		else $error("branch wrong");
endmodule

bind cpu_arith_branch_exec exec_checker i_exec_checker (.ref_clk(ref_clk),
	.reset(reset), .req_valid(req_valid), .req(req), .req_ready(req_ready),
	.flags_load_valid(flags_load_valid), .flags_load_data(flags_load_data),
	.pc(pc), .status_flags(status_flags), .wb(wb), .push(push), .pop(pop),
	.retire(retire), .op_cycles(op_cycles));

`default_nettype wire

// ==== bench/exec_feeder.sv ====
/*
 * Instruction source model: presents one decoded request and holds it
 * until the block takes it.
 * Assumes tasks are called just after a rising clock edge.
 */
`timescale 1ns/1ps
`default_nettype none

module exec_feeder (
	// clock
	input wire logic ref_clk,
	// request towards the block
	output logic req_valid,
	output exec_pkg::exec_req_t req,
	input wire logic req_ready
);
	initial begin
		req_valid = 1'b0;
		req = '0;
	end

	////////////////////////////////////////////////////////////////////////
	// ready is sampled mid-cycle so the drive above has settled
	task automatic send(input exec_pkg::exec_req_t r);
		logic ok;
		req_valid = 1'b1;
		req = r;
		do begin
			@(negedge ref_clk);
			ok = req_ready;
			@(posedge ref_clk);
			#1;
		end while (!ok);
	endtask

	// a released request shows garbage, never the stale word
	task automatic idle();
		req_valid = 1'b0;
		req = ~req;
	endtask
endmodule

`default_nettype wire

// ==== bench/cpu_arith_branch_exec_tb.sv ====
/*
 * Testbench: flag-load and back-to-back cases, then one table case per non-branch
 * operation, every flag branch over three flag patterns, and a reset case.
 * Assumes the feeder model and the bound checker.
 */
`timescale 1ns/1ps
`default_nettype none

`define CHK(act, exp) \
	begin \
		checks_done++; \
		if ((act) !== (exp)) begin \
			error_cnt++; \
			$display("unexpected at %0t: got %h expected %h", $time, act, exp); \
		end \
	end

module cpu_arith_branch_exec_tb;
	// operands a:b, offset (bits 2:0 tested bit, bit 11 two-word follower),
	// flags in:out, cycles, pc step or target, write kind, written value
	typedef struct packed {
		logic [15:0] ab;
		logic [11:0] off;
		logic [15:0] fl;
		logic [2:0] cyc;
		logic [15:0] epc;
		logic [1:0] wr;
		logic [15:0] dat;
	} row_t;
	// row index is the operation code
	localparam row_t cases_tbl [27] = '{
		'{16'h7F00, 12'h000, 16'h000C, 3'h1, 16'h0001, 2'h1, 16'h0080},
		'{16'h0100, 12'h000, 16'h0103, 3'h1, 16'h0001, 2'h1, 16'h0000},
		'{16'h8000, 12'h000, 16'h0804, 3'h1, 16'h0001, 2'h1, 16'h0080},
		'{16'h5500, 12'h000, 16'h0C02, 3'h1, 16'h0001, 2'h1, 16'h0000},
		'{16'h0000, 12'h000, 16'hA5A5, 3'h1, 16'h0001, 2'h1, 16'h00FF},
		'{16'h0055, 12'h000, 16'h0002, 3'h2, 16'h0001, 2'h2, 16'h0000},
		'{16'hFFFF, 12'h000, 16'h0300, 3'h2, 16'h0001, 2'h2, 16'h0001},
		'{16'hFF02, 12'h000, 16'h0201, 3'h2, 16'h0001, 2'h2, 16'hFFFE},
		'{16'hFFFF, 12'h000, 16'h0001, 3'h2, 16'h0001, 2'h2, 16'hFC02},
		'{16'h8040, 12'h000, 16'h0001, 3'h2, 16'h0001, 2'h2, 16'hC000},
		'{16'hFF80, 12'h000, 16'h0001, 3'h2, 16'h0001, 2'h2, 16'hFF00},
		'{16'h0000, 12'h005, 16'hFFFF, 3'h2, 16'h0006, 2'h0, 16'h0000},
		'{16'h0000, 12'h000, 16'hFFFF, 3'h2, 16'h1234, 2'h0, 16'h0000},
		'{16'h0000, 12'h000, 16'hFFFF, 3'h3, 16'h2345, 2'h0, 16'h0000},
		'{16'h0000, 12'hFFE, 16'hFFFF, 3'h3, 16'hFFFF, 2'h3, 16'h0001},
		'{16'h0000, 12'h000, 16'hFFFF, 3'h3, 16'h0100, 2'h3, 16'h0001},
		'{16'h0000, 12'h000, 16'hFFFF, 3'h4, 16'h0200, 2'h3, 16'h0002},
		'{16'h0000, 12'h000, 16'hFFFF, 3'h4, 16'h0456, 2'h0, 16'h0000},
		'{16'h0000, 12'h000, 16'h7FFF, 3'h4, 16'h0789, 2'h0, 16'h0000},
		'{16'h3333, 12'h800, 16'hFFFF, 3'h3, 16'h0003, 2'h0, 16'h0000},
		'{16'h1020, 12'h000, 16'h0005, 3'h1, 16'h0001, 2'h0, 16'h0000},
		'{16'h201F, 12'h000, 16'h0322, 3'h1, 16'h0001, 2'h0, 16'h0000},
		'{16'h8001, 12'h000, 16'h0028, 3'h1, 16'h0001, 2'h0, 16'h0000},
		'{16'hF7F7, 12'h003, 16'hFFFF, 3'h2, 16'h0002, 2'h0, 16'h0000},
		'{16'hF7F7, 12'h003, 16'h5555, 3'h1, 16'h0001, 2'h0, 16'h0000},
		'{16'h0808, 12'h003, 16'h0000, 3'h1, 16'h0001, 2'h0, 16'h0000},
		'{16'h0808, 12'h803, 16'hAAAA, 3'h3, 16'h0003, 2'h0, 16'h0000}};
	localparam logic [7:0] fpat [3] = '{8'h00, 8'hFF, 8'h55};
	localparam logic [11:0] offs [3] = '{12'hFFE, 12'h7FF, 12'h800};

	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic req_valid;
	exec_pkg::exec_req_t req;
	logic req_ready;
	logic flags_load_valid = 1'b0;
	exec_pkg::status_flags_t flags_load_data = 8'h00;
	logic [15:0] pc;
	exec_pkg::status_flags_t status_flags;
	exec_pkg::wb_t wb;
	exec_pkg::stack_op_t push;
	logic pop;
	logic retire;
	logic [2:0] op_cycles;
	int error_cnt = 0;
	int checks_done = 0;
	logic [15:0] pc0;
	logic tk;
	row_t r;

	always #2.5 ref_clk = ~ref_clk;

	exec_feeder i_exec_feeder (.ref_clk(ref_clk), .req_valid(req_valid),
		.req(req), .req_ready(req_ready));
	cpu_arith_branch_exec i_cpu_arith_branch_exec (.ref_clk(ref_clk),
		.reset(reset), .req_valid(req_valid), .req(req),
		.req_ready(req_ready), .flags_load_valid(flags_load_valid),
		.flags_load_data(flags_load_data), .pc(pc),
		.status_flags(status_flags), .wb(wb), .push(push), .pop(pop),
		.retire(retire), .op_cycles(op_cycles));

	////////////////////////////////////////////////////////////////////////
	function automatic exec_pkg::exec_req_t mk(input int k, input row_t c);
		exec_pkg::exec_req_t m;
		m = '0;
		m.op = exec_pkg::exec_op_t'(k);
		m.dest = 5'h10;
		m.rd_val = c.ab[15:8];
		m.rr_val = c.ab[7:0];
		m.imm = c.ab[7:0];
		m.io_val = c.ab[7:0];
		m.bit_sel = c.off[2:0];
		m.offset = c.off;
		m.target = c.epc;
		m.zptr = c.epc;
		m.stack_word = c.epc;
		m.next_two_word = c.off[11];
		return m;
	endfunction

	// k follows the branch order of the operation type; odd codes test set, except 33 and 37 which test clear
	function automatic logic br_cond(input int k, input logic [7:0] f,
		input logic [2:0] s);
		logic v;
		case (k)
			27, 28: v = f[s];
			29, 30: v = f[1];
			31, 32, 33, 34: v = f[0];
			35, 36: v = f[2];
			37, 38: v = f[2] ^ f[3];
			39, 40: v = f[5];
			41, 42: v = f[6];
			43, 44: v = f[3];
			default: v = f[7];
		endcase
		return (k inside {33, 34, 37, 38}) ? v ^ k[0] : v ^ k[0] ^ 1'b1;
	endfunction

	task automatic run(input int k, input row_t c);
		exec_pkg::exec_req_t q;
		logic ab;
		flags_load_valid = 1'b1;
		flags_load_data = c.fl[15:8];
		@(posedge ref_clk);
		#1;
		flags_load_valid = 1'b0;
		q = mk(k, c);
		ab = k inside {[12:13], [15:18]};
		pc0 = pc;
		i_exec_feeder.send(q);
		`CHK(retire, 1'b1)
		`CHK(op_cycles, c.cyc)
		`CHK(status_flags, c.fl[7:0])
		`CHK(pc, ab ? c.epc : pc0 + c.epc)
		`CHK(pop, k inside {17, 18})
		`CHK(push.valid, c.wr == 2'h3)
		if (c.wr == 2'h1)
			`CHK(wb[30:17], {6'h30, c.dat[7:0]})
		if (c.wr == 2'h2)
			`CHK({wb.pair_valid, wb.pair_data}, {1'b1, c.dat})
		if (c.wr == 2'h3)
			`CHK(push.addr, pc0 + c.dat)
		i_exec_feeder.idle();
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		#20000;
		error_cnt++;
		summarize();
	end

	initial begin
		repeat (4) @(posedge ref_clk);
		#1;
		reset = 1'b0;
		`CHK({pc, status_flags, req_ready}, {16'h0000, 8'h00, 1'b1})
		// a flag load in the accept cycle loses to the instruction
		pc0 = pc;
		flags_load_valid = 1'b1;
		flags_load_data = 8'hFF;
		i_exec_feeder.send(mk(0, cases_tbl[4]));
		flags_load_valid = 1'b0;
		`CHK(status_flags, 8'h00)
		i_exec_feeder.send(mk(1, cases_tbl[4]));
		`CHK(status_flags, 8'h04)
		i_exec_feeder.send(mk(5, cases_tbl[6]));
		i_exec_feeder.send(mk(1, cases_tbl[4]));
		`CHK({pc, status_flags}, {pc0 + 16'h0004, 8'h05})
		i_exec_feeder.idle();
		for (int k = 0; k < 27; k++)
			run(k, cases_tbl[k]);
		for (int k = 27; k < 47; k++) begin
			for (int p = 0; p < 3; p++) begin
				tk = br_cond(k, fpat[p], offs[p][2:0]);
				r = '{16'h0000, offs[p], {fpat[p], fpat[p]},
					tk ? 3'h2 : 3'h1,
					tk ? {{4{offs[p][11]}}, offs[p]} + 16'h0001 : 16'h0001,
					2'h0, 16'h0000};
				run(k, r);
			end
		end
		// reset while a four-cycle call is still running
		i_exec_feeder.send(mk(16, cases_tbl[16]));
		i_exec_feeder.idle();
		reset = 1'b1;
		@(posedge ref_clk);
		#1;
		reset = 1'b0;
		`CHK({pc, req_ready, retire}, {16'h0000, 1'b1, 1'b0})
		summarize();
	end
endmodule

`default_nettype wire
